// *** ifd_decoder.sv ***
`timescale 1ns/1ps
module ifd_decoder
  import ifd_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire logic [IW-1:0] i_instr,
  input wire logic i_test_true,
  input wire logic i_pc_change,
  output logic o_fetch,
  output logic o_cycle_end,
  output logic [1:0] o_phase,
  output logic o_idle_cycle,
  output ifd_fmt_t o_format,
  output logic [FILE_MSB:0] o_file_addr,
  output logic o_dest_file,
  output logic [BITNO_MSB-BITNO_LSB:0] o_bit_num,
  output logic [7:0] o_bit_mask,
  output logic [LIT8_MSB:0] o_lit8,
  output logic [LIT11_MSB:0] o_lit11,
  output logic o_is_call,
  output logic o_is_jump_absolute,
  output logic [OPC_MSB-BYTE_OPC_LSB:0] o_opcode
);
  typedef enum logic [0:0] {
    IFD_ST_EXEC = 1'b0,
    IFD_ST_IDLE = 1'b1
  } ifd_state_t;

  logic cyc_end;
  ifd_state_t state_reg;
  ifd_state_t state_next;
  ifd_fmt_t fmt_reg;
  ifd_fmt_t fmt_next;
  logic [FILE_MSB:0] file_reg;
  logic [FILE_MSB:0] file_next;
  logic dest_reg;
  logic dest_next;
  logic [2:0] bitn_reg;
  logic [2:0] bitn_next;
  logic [LIT8_MSB:0] lit8_reg;
  logic [LIT8_MSB:0] lit8_next;
  logic [LIT11_MSB:0] lit11_reg;
  logic [LIT11_MSB:0] lit11_next;
  logic call_reg;
  logic call_next;
  logic jmp_reg;
  logic jmp_next;
  logic [5:0] opc_reg;
  logic [5:0] opc_next;
  logic [7:0] mask_reg;
  logic [7:0] mask_next;

  ifd_phase_gen u_phase (
    .i_ref_clk(i_ref_clk),
    .i_rstn(i_rstn),
    .o_phase(o_phase),
    .o_cycle_end(cyc_end)
  );

  function automatic ifd_fmt_t fmt_of(input logic [IW-1:0] w);
    unique case (w[OPC_MSB:OPC_GRP_LSB])
      GRP_BYTE: fmt_of = IFD_FMT_BYTE;
      GRP_BIT: fmt_of = IFD_FMT_BIT;
      GRP_LONG: fmt_of = IFD_FMT_LONG;
      GRP_LIT: fmt_of = IFD_FMT_LIT;
    endcase
  endfunction

  // ----------------------------------------
  // field capture and cycle sequencing
  // ----------------------------------------
  always_comb
  begin
    state_next = state_reg;
    fmt_next = fmt_reg;
    file_next = file_reg;
    dest_next = dest_reg;
    bitn_next = bitn_reg;
    lit8_next = lit8_reg;
    lit11_next = lit11_reg;
    call_next = call_reg;
    jmp_next = jmp_reg;
    opc_next = opc_reg;
    mask_next = mask_reg;
    if (cyc_end)
    begin
      unique case (state_reg)
        IFD_ST_EXEC:
        begin
          // two cycles when skip taken or pc altered
          if (i_test_true || i_pc_change)
            state_next = IFD_ST_IDLE;
          else
            state_next = IFD_ST_EXEC;
          fmt_next = fmt_of(i_instr);
          file_next = i_instr[FILE_MSB:0];
          dest_next = i_instr[TGT_BIT];
          bitn_next = i_instr[BITNO_MSB:BITNO_LSB];
          mask_next = 8'h01 << i_instr[BITNO_MSB:BITNO_LSB];
          lit8_next = i_instr[LIT8_MSB:0];
          lit11_next = i_instr[LIT11_MSB:0];
          call_next = (i_instr[OPC_MSB:LONG_OPC_LSB] == LONG_OPC_CALL);
          jmp_next = (i_instr[OPC_MSB:LONG_OPC_LSB] == LONG_OPC_JUMP);
          // opcode keeps only format-defined bits; x bits not inspected
          unique case (fmt_of(i_instr))
            IFD_FMT_BIT: opc_next = {2'h0, i_instr[OPC_MSB:BIT_OPC_LSB]};
            IFD_FMT_LONG: opc_next = {3'h0, i_instr[OPC_MSB:LONG_OPC_LSB]};
            IFD_FMT_BYTE, IFD_FMT_LIT: opc_next = i_instr[OPC_MSB:BYTE_OPC_LSB];
          endcase
        end
        IFD_ST_IDLE:
          state_next = IFD_ST_EXEC;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rstn)
    begin
      state_reg <= IFD_ST_EXEC;
      fmt_reg <= IFD_FMT_BYTE;
      file_reg <= '0;
      dest_reg <= 1'b0;
      bitn_reg <= 3'h0;
      lit8_reg <= '0;
      lit11_reg <= '0;
      call_reg <= 1'b0;
      jmp_reg <= 1'b0;
      opc_reg <= 6'h00;
      mask_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
      fmt_reg <= fmt_next;
      file_reg <= file_next;
      dest_reg <= dest_next;
      bitn_reg <= bitn_next;
      lit8_reg <= lit8_next;
      lit11_reg <= lit11_next;
      call_reg <= call_next;
      jmp_reg <= jmp_next;
      opc_reg <= opc_next;
      mask_reg <= mask_next;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign o_cycle_end = cyc_end;
  assign o_fetch = cyc_end && (state_reg == IFD_ST_EXEC);
  assign o_idle_cycle = (state_reg == IFD_ST_IDLE);
  assign o_format = fmt_reg;
  assign o_file_addr = file_reg;
  assign o_dest_file = dest_reg;
  assign o_bit_num = bitn_reg;
  assign o_bit_mask = mask_reg;
  assign o_lit8 = lit8_reg;
  assign o_lit11 = lit11_reg;
  assign o_is_call = call_reg;
  assign o_is_jump_absolute = jmp_reg;
  assign o_opcode = opc_reg;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_taken;
    o_fetch && (i_test_true || i_pc_change);
  endsequence
  sequence s_idle_span;
    o_idle_cycle [*4] ##1 !o_idle_cycle;
  endsequence

  property p_idle_after;
    @(posedge i_ref_clk) disable iff (!i_rstn) s_taken |=> s_idle_span;
  endproperty
  a_idle_after: assert property (p_idle_after)
    else $error("idle cycle missing after skip or jump");

  property p_single;
    @(posedge i_ref_clk) disable iff (!i_rstn)
      o_fetch && !i_test_true && !i_pc_change
        |=> (!o_idle_cycle && !o_fetch) [*3] ##1 o_fetch;
  endproperty
  a_single: assert property (p_single)
    else $error("plain instruction took more than one cycle");

  property p_file;
    @(posedge i_ref_clk) disable iff (!i_rstn)
      o_fetch |=> o_file_addr == $past(i_instr[FILE_MSB:0]);
  endproperty
  a_file: assert property (p_file)
    else $error("file address wrong");

  property p_dest;
    @(posedge i_ref_clk) disable iff (!i_rstn)
      o_fetch |=> o_dest_file == $past(i_instr[TGT_BIT]);
  endproperty
  a_dest: assert property (p_dest)
    else $error("target select wrong");

  property p_mask;
    @(posedge i_ref_clk) disable iff (!i_rstn)
      o_fetch |=> $onehot(o_bit_mask) && o_bit_mask[$past(i_instr[BITNO_MSB:BITNO_LSB])];
  endproperty
  a_mask: assert property (p_mask)
    else $error("bit mask wrong");

  property p_lit8;
    @(posedge i_ref_clk) disable iff (!i_rstn)
      o_fetch |=> o_lit8 == $past(i_instr[LIT8_MSB:0]);
  endproperty
  a_lit8: assert property (p_lit8)
    else $error("eight-bit literal wrong");

  property p_jump;
    @(posedge i_ref_clk) disable iff (!i_rstn)
      o_fetch && i_instr[OPC_MSB:LONG_OPC_LSB] == LONG_OPC_JUMP
        |=> o_is_jump_absolute && !o_is_call && o_lit11 == $past(i_instr[LIT11_MSB:0]);
  endproperty
  a_jump: assert property (p_jump)
    else $error("jump target wrong");

  property p_call;
    @(posedge i_ref_clk) disable iff (!i_rstn)
      o_fetch && i_instr[OPC_MSB:LONG_OPC_LSB] == LONG_OPC_CALL
        |=> o_is_call && !o_is_jump_absolute && o_format == IFD_FMT_LONG
        && o_lit11 == $past(i_instr[LIT11_MSB:0]);
  endproperty
  a_call: assert property (p_call)
    else $error("call target wrong");

  property p_bitop;
    @(posedge i_ref_clk) disable iff (!i_rstn)
      o_fetch && i_instr[OPC_MSB:OPC_GRP_LSB] == GRP_BIT |=> o_format == IFD_FMT_BIT
        && o_opcode == {2'h0, $past(i_instr[OPC_MSB:BIT_OPC_LSB])};
  endproperty
  a_bitop: assert property (p_bitop)
    else $error("bit format opcode wrong");

  property p_byteop;
    @(posedge i_ref_clk) disable iff (!i_rstn)
      o_fetch && i_instr[OPC_MSB:OPC_GRP_LSB] == GRP_BYTE |=> o_format == IFD_FMT_BYTE
        && o_opcode == $past(i_instr[OPC_MSB:BYTE_OPC_LSB]);
  endproperty
  a_byteop: assert property (p_byteop)
    else $error("byte format opcode wrong");
endmodule

// *** ifd_decoder_bench.sv ***
`timescale 1ns/1ps
module ifd_decoder_bench;
  import ifd_pkg::*;
  localparam int N = 64;
  logic i_ref_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic i_test_true = 1'b0;
  logic i_pc_change = 1'b0;
  logic [IW-1:0] i_instr;
  logic o_fetch, o_cycle_end, o_idle_cycle, o_dest_file, o_is_call, o_is_jump_absolute;
  logic [1:0] o_phase;
  ifd_fmt_t o_format;
  logic [6:0] o_file_addr;
  logic [2:0] o_bit_num;
  logic [7:0] o_bit_mask, o_lit8;
  logic [10:0] o_lit11;
  logic [5:0] o_opcode;
  int err_count = 0;
  int n_compared = 0;
  // ------------------------------
  // clock, flags, instances
  // ------------------------------
  always #5 i_ref_clk = ~i_ref_clk;
  always @(posedge i_ref_clk)
  begin
    i_test_true <= i_rstn & ($urandom_range(0, 3) == 0);
    i_pc_change <= i_rstn & ($urandom_range(0, 3) == 0);
  end
  ifd_progmem #(.N(N)) u_mem (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_fetch(o_fetch),
    .i_phase(o_phase), .o_word(i_instr));
  ifd_decoder u_dut (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_instr(i_instr),
    .i_test_true(i_test_true), .i_pc_change(i_pc_change), .o_fetch(o_fetch),
    .o_cycle_end(o_cycle_end), .o_phase(o_phase), .o_idle_cycle(o_idle_cycle),
    .o_format(o_format), .o_file_addr(o_file_addr), .o_dest_file(o_dest_file),
    .o_bit_num(o_bit_num), .o_bit_mask(o_bit_mask), .o_lit8(o_lit8), .o_lit11(o_lit11),
    .o_is_call(o_is_call), .o_is_jump_absolute(o_is_jump_absolute), .o_opcode(o_opcode));
  // ------------------------------
  // expectation helpers
  // ------------------------------
  function automatic logic [15:0] exp_fmt(input logic [IW-1:0] w);
    case (w[13:12])
      2'h0: return 16'(IFD_FMT_BYTE);
      2'h1: return 16'(IFD_FMT_BIT);
      2'h2: return 16'(IFD_FMT_LONG);
      default: return 16'(IFD_FMT_LIT);
    endcase
  endfunction
  function automatic logic [15:0] exp_opc(input logic [IW-1:0] w);
    if (w[13:12] == 2'h1)
      return 16'(w[13:10]);
    if (w[13:12] == 2'h2)
      return 16'(w[13:11]);
    return 16'(w[13:8]);
  endfunction
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic conclude();
    if (err_count == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // ------------------------------
  // main sequence
  // ------------------------------
  initial
  begin
    logic [IW-1:0] w;
    logic flg;
    int gap;
    logic [IW-1:0] corner [0:7];
    corner = '{14'h3FFF, 14'h0000, 14'h27FF, 14'h2800, 14'h1380, 14'h007F, 14'h3D00, 14'h0C80};
    w = IW'($urandom(64));
    for (int k = 0; k < N; k++)
      u_mem.mem[k] = (k < 8) ? corner[k] : IW'($urandom());
    repeat (4) @(posedge i_ref_clk);
    i_rstn <= 1'b1;
    #1;
    chk("rst_format", 16'(o_format), 16'(IFD_FMT_BYTE));
    chk("rst_lit11", 16'(o_lit11), 16'h0000);
    flg = 1'b0;
    for (int n = 0; n < N; n++)
    begin
      gap = 0;
      do
      begin
        @(negedge i_ref_clk);
        gap++;
      end while (o_fetch !== 1'b1 && gap < 12);
      chk("gap", 16'(gap), flg ? 16'h0008 : 16'h0004);
      if (gap >= 12)
        break;
      chk("phase", 16'(o_phase), 16'(PHASE_LAST));
      chk("cycle_end", 16'(o_cycle_end), 16'h0001);
      chk("idle_at_fetch", 16'(o_idle_cycle), 16'h0000);
      w = u_mem.mem[n];
      flg = i_test_true | i_pc_change;
      @(posedge i_ref_clk);
      #1;
      chk("idle", 16'(o_idle_cycle), 16'(flg));
      chk("format", 16'(o_format), exp_fmt(w));
      chk("opcode", 16'(o_opcode), exp_opc(w));
      chk("file", 16'(o_file_addr), 16'(w[6:0]));
      chk("dest", 16'(o_dest_file), 16'(w[7]));
      chk("bitnum", 16'(o_bit_num), 16'(w[9:7]));
      chk("mask", 16'(o_bit_mask), 16'(8'h01 << w[9:7]));
      chk("lit8", 16'(o_lit8), 16'(w[7:0]));
      chk("lit11", 16'(o_lit11), 16'(w[10:0]));
      chk("call", 16'(o_is_call), 16'(w[13:11] == 3'h4));
      chk("jump", 16'(o_is_jump_absolute), 16'(w[13:11] == 3'h5));
    end
    conclude();
  end
endmodule

// *** ifd_phase_gen.sv ***
`timescale 1ns/1ps
module ifd_phase_gen
  import ifd_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  output logic [1:0] o_phase,
  output logic o_cycle_end
);
  logic [1:0] phase_reg;
  logic [1:0] phase_next;

  // ----------------------------------------
  // four oscillator periods per cycle
  // ----------------------------------------
  always_comb
  begin
    phase_next = phase_reg + 2'h1;
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rstn)
      phase_reg <= 2'h0;
    else
      phase_reg <= phase_next;
  end

  assign o_phase = phase_reg;
  assign o_cycle_end = (phase_reg == PHASE_LAST);

  property p_four_periods;
    @(posedge i_ref_clk) disable iff (!i_rstn)
      o_cycle_end |=> !o_cycle_end [*3] ##1 o_cycle_end;
  endproperty
  a_four_periods: assert property (p_four_periods)
    else $error("instruction cycle not four periods");
endmodule

// *** ifd_pkg.sv ***
// Behaviour
// - register operand is seven-bit file address
// - target bit zero accumulator, one file
// - bit field picks one of eight bits
// - don't-care instruction bits never change decoding
// - plain instruction finishes in one cycle
// - skip or jump adds idle second cycle
// - instruction cycle is four oscillator periods
// - literal group carries eight-bit immediate
// - call and jump: 3-bit opcode, 11-bit target
package ifd_pkg;
  localparam int IW = 14;
  localparam int FILE_MSB = 6;
  localparam int TGT_BIT = 7;
  localparam int BITNO_MSB = 9;
  localparam int BITNO_LSB = 7;
  localparam int LIT8_MSB = 7;
  localparam int LIT11_MSB = 10;
  localparam int OPC_MSB = 13;
  localparam int OPC_GRP_LSB = 12;
  localparam int BYTE_OPC_LSB = 8;
  localparam int BIT_OPC_LSB = 10;
  localparam int LONG_OPC_LSB = 11;
  localparam int OSC_PER_CYC = 4;
  localparam logic [1:0] GRP_BYTE = 2'h0;
  localparam logic [1:0] GRP_BIT = 2'h1;
  localparam logic [1:0] GRP_LONG = 2'h2;
  localparam logic [1:0] GRP_LIT = 2'h3;
  localparam logic [2:0] LONG_OPC_CALL = 3'h4;
  localparam logic [2:0] LONG_OPC_JUMP = 3'h5;
  localparam logic [1:0] PHASE_LAST = 2'h3;
  typedef enum logic [1:0] {
    IFD_FMT_BYTE = 2'b00,
    IFD_FMT_BIT = 2'b01,
    IFD_FMT_LIT = 2'b10,
    IFD_FMT_LONG = 2'b11
  } ifd_fmt_t;
endpackage

// *** ifd_progmem.sv ***
`timescale 1ns/1ps
module ifd_progmem
  import ifd_pkg::*;
#(
  parameter int N = 64
)
(
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire logic i_fetch,
  input wire logic [1:0] i_phase,
  output logic [IW-1:0] o_word
);
  // ------------------------------
  // word store and fetch pointer
  // ------------------------------
  logic [IW-1:0] mem [0:N-1];
  logic [$clog2(N)-1:0] idx_reg;
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rstn)
      idx_reg <= '0;
    else if (i_fetch)
      idx_reg <= idx_reg + 1'b1;
  end
  // word valid in periods 1 and 3 (last), inverted in periods 0 and 2
  assign o_word = (i_phase == PHASE_LAST) ? mem[idx_reg] : ~mem[idx_reg] ^ {IW{i_phase[0]}};
endmodule
